// ==== psmc_cpu_model.sv ====
// partner model: cpu core instruction issue and the interrupt and reset wake sources
`timescale 1ns/10ps
module psmc_cpu_model (
  input  wire logic       clk_sys_in,
  input  wire logic       service_irq_in,
  input  wire logic       reset_vector_in,
  output logic            instr_valid_out,
  output logic      [7:0] opcode_out,
  output logic            wfi_out,
  output logic            irq_any_out,
  output logic            irq_ext_out,
  output logic            irq_halt_out,
  output logic            irq_time_base_out,
  output logic            wake_reset_out
);
  initial begin
    {instr_valid_out, wfi_out, opcode_out} = 10'h000;
    {wake_reset_out, irq_time_base_out, irq_halt_out, irq_ext_out, irq_any_out} = 5'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one instruction per call; opcode is only qualified while valid, so it is scrambled after
  task automatic exec(input logic [7:0] op, input logic wait_for_interrupt_instr);
    @(posedge clk_sys_in);
    instr_valid_out <= ~wait_for_interrupt_instr;
    wfi_out         <= wait_for_interrupt_instr;
    opcode_out      <= op;
    @(posedge clk_sys_in);
    instr_valid_out <= 1'b0;
    wfi_out         <= 1'b0;
    opcode_out      <= ~op;
  endtask : exec
  // mask order: reset wake, time base, halt-capable, external, any
  task automatic raise(input logic [4:0] m);
    @(posedge clk_sys_in);
    {wake_reset_out, irq_time_base_out, irq_halt_out, irq_ext_out, irq_any_out} <= m;
  endtask : raise
  ////////////////////////////////////////////////////////////////////////////////
  // request latches drop when the vector is fetched, like hardware interrupt sources
  always @(posedge clk_sys_in) begin
    if (service_irq_in === 1'b1 || reset_vector_in === 1'b1) begin
      {wake_reset_out, irq_time_base_out, irq_halt_out, irq_ext_out, irq_any_out} <= 5'h00;
    end
  end
endmodule : psmc_cpu_model

// ==== psmc_ctrl.sv ====
// power saving mode controller: run, slow, wait, slow-wait, active-halt and halt sequencing
`timescale 1ns/10ps

// Function
// - after reset the block runs with cpu and peripherals on the full master clock
// - slow mode enable divides the master clock by 2, 4, 8 or 16
// - wait entered from slow mode becomes slow-wait, peripherals keep divided clock
// - wait instruction stops the cpu, peripherals run on the current clock
// - entering wait forces the interrupt priority bits to binary 10
// - wait ends on any interrupt or reset, starting service or reset routine
// - the cpu stacks and restores the priority bits when servicing the wake interrupt
// - halt opcode enters halt when oscillator irq enable is 0, active-halt when 1
// - in active-halt only oscillator and time base run
// - active-halt ends on external, time-base irq or reset; irq wake has no delay
// - leaving active-halt uses the stabilisation delay only for reset wake
// - entering either halt forces priority bits to 10; pending irq wakes at once from active-halt, after the stabilisation delay from halt
// - with oscillator irq enable set, active-halt never causes a watchdog reset
// - halt switches the oscillator off and stops everything internal
// - halt exit restarts the oscillator and waits 256 or 4096 cycles first
// - an option bit chooses the 256 or 4096 cycle delay
// - a watchdog-halt option decides if halt with watchdog running gives a reset
// - opcode 8E is decoded as the halt instruction
module psmc_ctrl #(
  parameter logic [12:0] STAB_SHORT = 13'(psmc_pkg::STAB_SHORT_CYC),
  parameter logic [12:0] STAB_LONG  = 13'(psmc_pkg::STAB_LONG_CYC)
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        clk_en_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // cpu core
  input  wire logic        instr_valid_in,
  input  wire logic [7:0]  opcode_in,
  input  wire logic        wait_for_interrupt_instr_in,
  output logic             cc_force_out,
  output logic      [1:0]  cc_force_value_out,
  output logic             service_irq_out,
  output logic             reset_vector_out,
  // interrupt and reset sources
  input  wire logic        irq_any_in,
  input  wire logic        irq_ext_in,
  input  wire logic        irq_halt_in,
  input  wire logic        irq_time_base_in,
  input  wire logic        wake_reset_in,
  input  wire logic        wdg_enabled_in,
  output logic             wdg_reset_out,
  // clock controller
  output logic             cpu_clk_en_out,
  output logic             periph_clk_en_out,
  output logic             time_base_clk_en_out,
  output logic             osc_enable_out,
  output logic      [2:0]  mode_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [3:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    div_mask = 4'h1;
      2'h1:    div_mask = 4'h3;
      2'h2:    div_mask = 4'h7;
      default: div_mask = 4'hF;
    endcase
  endfunction : div_mask

  function automatic logic is_cpu_mode(input psmc_pkg::psmc_state_t st);
    is_cpu_mode = (st == psmc_pkg::ST_RUN) || (st == psmc_pkg::ST_SLOW);
  endfunction : is_cpu_mode

  function automatic logic is_halt_op(input logic [7:0] op);
    is_halt_op = (op == psmc_pkg::HALT_OPCODE);
  endfunction : is_halt_op

  ////////////////////////////////////////////////////////////////////////////////
  // state

  psmc_pkg::psmc_regs_t r_reg;
  psmc_pkg::psmc_regs_t r_next;

  logic       slow_mode_enable_bit;
  logic [1:0] slow_divider_select;
  logic       oscillator_interrupt_enable;
  logic       long_delay_option;
  logic       watchdog_halt_option;
  logic       cpu_active;
  logic       guard_abort;
  logic       halt_go;
  logic       wfi_go;
  logic       apb_setup;
  logic       apb_write;
  logic       addr_ok;
  logic [12:0] dly_load;
  psmc_pkg::psmc_state_t awake_state;

  assign slow_mode_enable_bit        = r_reg.ctrl[psmc_pkg::CTRL_SLOW_BIT];
  assign slow_divider_select         = r_reg.ctrl[psmc_pkg::CTRL_DIV_LSB +: 2];
  assign oscillator_interrupt_enable = r_reg.ctrl[psmc_pkg::CTRL_OIE_BIT];
  assign long_delay_option           = r_reg.ctrl[psmc_pkg::CTRL_LONGDLY_BIT];
  assign watchdog_halt_option        = r_reg.ctrl[psmc_pkg::CTRL_WDGH_BIT];

  assign cpu_active  = is_cpu_mode(r_reg.state);
  // post-wake guard: oscillator irq enable dropped before the delay expired
  assign guard_abort = cpu_active && r_reg.guard && (r_reg.dly_cnt != 13'h0000) &&
                       !oscillator_interrupt_enable;
  assign halt_go     = cpu_active && !guard_abort && !wake_reset_in &&
                       instr_valid_in && is_halt_op(opcode_in);
  assign wfi_go      = cpu_active && !guard_abort && !wake_reset_in && !halt_go &&
                       wait_for_interrupt_instr_in;
  assign dly_load    = long_delay_option ? STAB_LONG - 13'h0001
                                         : STAB_SHORT - 13'h0001;
  assign awake_state = slow_mode_enable_bit ? psmc_pkg::ST_SLOW : psmc_pkg::ST_RUN;

  assign apb_setup = psel_in && !penable_in;
  assign apb_write = psel_in && penable_in && pwrite_in && clk_en_in;
  assign addr_ok   = (paddr_in == psmc_pkg::ADDR_CTRL) || (paddr_in == psmc_pkg::ADDR_STATUS);

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic tick;
    tick = 1'b0;
    r_next          = r_reg;
    r_next.cc_force = 1'b0;
    r_next.service  = 1'b0;
    r_next.rst_vec  = 1'b0;
    r_next.wdg_rst  = 1'b0;
    r_next.div_cnt  = r_reg.div_cnt + 4'h1;
    if (r_reg.dly_cnt != 13'h0000) begin
      r_next.dly_cnt = r_reg.dly_cnt - 13'h0001;
    end
    // one tick per divided period; run mode ticks every master cycle
    tick = !slow_mode_enable_bit ||
           ((r_reg.div_cnt & div_mask(slow_divider_select)) ==
            div_mask(slow_divider_select));

    // apb: read data captured in setup, write lands at the access edge
    if (apb_setup) begin
      r_next.pslverr = !addr_ok;
      r_next.prdata  = 32'h0000_0000;
      if (paddr_in == psmc_pkg::ADDR_CTRL) begin
        r_next.prdata[psmc_pkg::CTRL_WIDTH-1:0] = r_reg.ctrl;
      end else if (paddr_in == psmc_pkg::ADDR_STATUS) begin
        r_next.prdata[psmc_pkg::STAT_MODE_LSB +: 3] = r_reg.state;
        r_next.prdata[psmc_pkg::STAT_GUARD_BIT]     = r_reg.guard;
        r_next.prdata[psmc_pkg::STAT_WAKE_LSB +: 2] = r_reg.wake;
      end
    end
    if (apb_write && (paddr_in == psmc_pkg::ADDR_CTRL)) begin
      r_next.ctrl = pwdata_in[psmc_pkg::CTRL_WIDTH-1:0];
    end

    case (r_reg.state)
      psmc_pkg::ST_RUN, psmc_pkg::ST_SLOW: begin
        r_next.state = awake_state;
        if (r_reg.guard && (r_reg.dly_cnt == 13'h0000)) begin
          r_next.guard = 1'b0;
        end
        if (guard_abort) begin
          r_next.state = psmc_pkg::ST_STAB;
          r_next.wake  = psmc_pkg::WK_RESUME;
          r_next.guard = 1'b0;
        end else if (wake_reset_in) begin
          r_next.rst_vec = 1'b1;
        end else if (halt_go) begin
          r_next.cc_force = 1'b1;
          r_next.guard    = 1'b0;
          if (oscillator_interrupt_enable) begin
            r_next.state = psmc_pkg::ST_ACT_HALT;
          end else begin
            r_next.state   = psmc_pkg::ST_HALT;
            r_next.wdg_rst = wdg_enabled_in && watchdog_halt_option;
          end
        end else if (wfi_go) begin
          r_next.cc_force = 1'b1;
          r_next.state    = slow_mode_enable_bit ? psmc_pkg::ST_SLOW_WAIT
                                                 : psmc_pkg::ST_WAIT;
        end
      end
      psmc_pkg::ST_WAIT, psmc_pkg::ST_SLOW_WAIT: begin
        if (wake_reset_in) begin
          r_next.rst_vec = 1'b1;
          r_next.state   = awake_state;
        end else if (irq_any_in) begin
          r_next.service = 1'b1;
          r_next.state   = awake_state;
        end
      end
      psmc_pkg::ST_ACT_HALT: begin
        if (wake_reset_in) begin
          r_next.state   = psmc_pkg::ST_STAB;
          r_next.wake    = psmc_pkg::WK_RESET;
          r_next.dly_cnt = dly_load;
        end else if (irq_ext_in || irq_time_base_in) begin
          r_next.service = 1'b1;
          r_next.state   = awake_state;
          if (irq_time_base_in) begin
            r_next.guard   = 1'b1;
            r_next.dly_cnt = dly_load;
          end
        end
      end
      psmc_pkg::ST_HALT: begin
        if (wake_reset_in) begin
          r_next.state   = psmc_pkg::ST_STAB;
          r_next.wake    = psmc_pkg::WK_RESET;
          r_next.dly_cnt = dly_load;
        end else if (irq_halt_in) begin
          r_next.state   = psmc_pkg::ST_STAB;
          r_next.wake    = psmc_pkg::WK_IRQ;
          r_next.dly_cnt = dly_load;
        end
      end
      psmc_pkg::ST_STAB: begin
        if (r_reg.dly_cnt == 13'h0000) begin
          r_next.state   = awake_state;
          r_next.service = (r_reg.wake == psmc_pkg::WK_IRQ);
          r_next.rst_vec = (r_reg.wake == psmc_pkg::WK_RESET);
        end
      end
      default: begin
        r_next.state = psmc_pkg::ST_RUN;
      end
    endcase

    // clock gates follow the mode being entered
    r_next.cpu_en = tick && is_cpu_mode(r_next.state);
    r_next.per_en = tick && (is_cpu_mode(r_next.state) ||
                             (r_next.state == psmc_pkg::ST_WAIT) ||
                             (r_next.state == psmc_pkg::ST_SLOW_WAIT));
    // a guard abort rests in the stab state with the oscillator running, not in full halt
    r_next.osc_en = (r_next.state != psmc_pkg::ST_HALT);
    r_next.tb_en  = (r_next.state != psmc_pkg::ST_HALT);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      r_reg <= psmc_pkg::REGS_RESET;
    end else if (clk_en_in) begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata_out           = r_reg.prdata;
  // no wait states: an enabled access phase completes in its first cycle
  assign pready_out           = clk_en_in;
  assign pslverr_out          = r_reg.pslverr;
  assign cc_force_out         = r_reg.cc_force;
  assign cc_force_value_out   = psmc_pkg::CC_FORCE_VAL;
  assign service_irq_out      = r_reg.service;
  assign reset_vector_out     = r_reg.rst_vec;
  assign wdg_reset_out        = r_reg.wdg_rst;
  assign cpu_clk_en_out       = r_reg.cpu_en;
  assign periph_clk_en_out    = r_reg.per_en;
  assign time_base_clk_en_out = r_reg.tb_en;
  assign osc_enable_out       = r_reg.osc_en;
  assign mode_out             = r_reg.state;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  chk_run_full_clock: assert property (
    (r_reg.state == psmc_pkg::ST_RUN) && (r_next.state == psmc_pkg::ST_RUN) && clk_en_in
    |=> cpu_clk_en_out && periph_clk_en_out)
    else $error("run mode lost the full cpu clock");

  chk_slow_divided: assert property (
    (r_reg.state == psmc_pkg::ST_SLOW) && (r_next.state == psmc_pkg::ST_SLOW) &&
    cpu_clk_en_out && clk_en_in
    |=> !cpu_clk_en_out)
    else $error("slow mode cpu clock not divided");

  chk_slow_wait_entry: assert property (
    (r_reg.state == psmc_pkg::ST_SLOW) && wfi_go && clk_en_in
    |=> mode_out == psmc_pkg::ST_SLOW_WAIT)
    else $error("wait from slow did not enter slow-wait");

  chk_wait_cpu_stop: assert property (
    ((r_reg.state == psmc_pkg::ST_WAIT) || (r_reg.state == psmc_pkg::ST_SLOW_WAIT))
    |-> !cpu_clk_en_out && osc_enable_out)
    else $error("cpu clocked during wait");

  chk_wait_cc_force: assert property (
    wfi_go && clk_en_in |=> cc_force_out && (cc_force_value_out == 2'h2))
    else $error("priority bits not forced on wait entry");

  chk_wait_wake_irq: assert property (
    (r_reg.state == psmc_pkg::ST_WAIT) && irq_any_in && !wake_reset_in && clk_en_in
    |=> service_irq_out && (mode_out == psmc_pkg::ST_RUN))
    else $error("wait not left on interrupt");

  chk_halt_select: assert property (
    halt_go && clk_en_in |=> (mode_out == (($past(oscillator_interrupt_enable)) ?
                             psmc_pkg::ST_ACT_HALT : psmc_pkg::ST_HALT)))
    else $error("halt opcode chose the wrong halt mode");

  chk_act_halt_fast: assert property (
    (r_reg.state == psmc_pkg::ST_ACT_HALT) && irq_time_base_in && !wake_reset_in &&
    clk_en_in |=> service_irq_out && cpu_active)
    else $error("active-halt irq wake was delayed");

  chk_act_halt_gates: assert property (
    (r_reg.state == psmc_pkg::ST_ACT_HALT)
    |-> !periph_clk_en_out && time_base_clk_en_out && osc_enable_out)
    else $error("wrong clocks in active-halt");

  chk_halt_osc_off: assert property (
    (r_reg.state == psmc_pkg::ST_HALT)
    |-> !osc_enable_out && !periph_clk_en_out && !cpu_clk_en_out)
    else $error("oscillator running in halt");

  chk_halt_stab_hold: assert property (
    (r_reg.state == psmc_pkg::ST_HALT) && irq_halt_in && !wake_reset_in && clk_en_in
    ##1 clk_en_in[*8]
    |-> (mode_out == psmc_pkg::ST_STAB) && !service_irq_out)
    else $error("halt wake skipped the stabilisation delay");

  chk_no_wdg_active: assert property (
    halt_go && oscillator_interrupt_enable && clk_en_in |=> !wdg_reset_out)
    else $error("watchdog reset on active-halt entry");

  // wake paths, delay length and watchdog option
  chk_wait_wake_reset: assert property (
    ((r_reg.state == psmc_pkg::ST_WAIT) || (r_reg.state == psmc_pkg::ST_SLOW_WAIT)) &&
    wake_reset_in && clk_en_in |=> reset_vector_out && !service_irq_out)
    else $error("wait not left through the reset routine");
  chk_act_reset_delay: assert property (
    (r_reg.state == psmc_pkg::ST_ACT_HALT) && wake_reset_in && clk_en_in
    |=> (mode_out == psmc_pkg::ST_STAB) && !reset_vector_out && !service_irq_out)
    else $error("active-halt reset wake skipped the delay");
  chk_halt_cc_force: assert property (
    halt_go && clk_en_in |=> cc_force_out && (cc_force_value_out == 2'h2))
    else $error("priority bits not forced on halt entry");
  chk_guard_stop: assert property (
    guard_abort && clk_en_in
    |=> (mode_out == psmc_pkg::ST_STAB) && !cpu_clk_en_out && !periph_clk_en_out)
    else $error("early oscillator irq disable did not stop processing");
  chk_stab_release: assert property (
    (r_reg.state == psmc_pkg::ST_STAB) && (r_reg.dly_cnt == 13'h0000) &&
    (r_reg.wake == psmc_pkg::WK_IRQ) && clk_en_in |=> service_irq_out && cpu_active)
    else $error("halt wake did not resume with the interrupt service");
  chk_stab_load: assert property (
    (r_reg.state == psmc_pkg::ST_HALT) && (irq_halt_in || wake_reset_in) && clk_en_in
    |=> r_reg.dly_cnt == ($past(long_delay_option) ? STAB_LONG : STAB_SHORT) - 13'h0001)
    else $error("stabilisation delay length does not follow the option bit");
  chk_halt_wdg_opt: assert property (
    halt_go && !oscillator_interrupt_enable && clk_en_in
    |=> wdg_reset_out == ($past(wdg_enabled_in) && $past(watchdog_halt_option)))
    else $error("watchdog reset does not follow the halt option");
  chk_other_opcode: assert property (
    cpu_active && instr_valid_in && !is_halt_op(opcode_in) && !wait_for_interrupt_instr_in &&
    clk_en_in |=> (mode_out != psmc_pkg::ST_HALT) && (mode_out != psmc_pkg::ST_ACT_HALT))
    else $error("a non-halt opcode entered a halt mode");

  cov_wait_wake:   cover property ((r_reg.state == psmc_pkg::ST_WAIT) ##1 service_irq_out);
  cov_act_wake:    cover property ((r_reg.state == psmc_pkg::ST_ACT_HALT) ##1 service_irq_out);
  cov_halt_stab:   cover property ((r_reg.state == psmc_pkg::ST_STAB) ##1 service_irq_out);
  cov_guard_abort: cover property (guard_abort && clk_en_in);
  cov_reset_wake:  cover property ((r_reg.state == psmc_pkg::ST_STAB) ##1 reset_vector_out);

endmodule : psmc_ctrl

// ==== psmc_ctrl_tb.sv ====
// self-checking bench for the power mode controller: apb registers, sleep entry and wake-up
`timescale 1ns/10ps
module psmc_ctrl_tb;
  localparam logic [12:0] SHORT_N = 13'h0008;
  localparam logic [12:0] LONG_N  = 13'h0010;
  logic        clk_sys_in, rst_in, clk_en, psel, penable, pwrite, pready, pslverr, wdg_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        iv, wait_for_interrupt_instr, iany, iext, ihalt, itb, wrst, ccf, srv, rvec, wdgr, vec;
  logic        cpu_en, per_en, tb_en, osc_en, err;
  logic [7:0]  op;
  logic [1:0]  ccv;
  logic [2:0]  mode;
  logic [4:0]  src [3] = '{5'h08, 5'h02, 5'h10};
  int          fail_count, n_compared, cyc, wdg_n, cpu_n, per_n, dt, c0, p0, w0;

  psmc_ctrl #(.STAB_SHORT(SHORT_N), .STAB_LONG(LONG_N)) dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .clk_en_in(clk_en),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .instr_valid_in(iv), .opcode_in(op), .wait_for_interrupt_instr_in(wait_for_interrupt_instr),
    .cc_force_out(ccf), .cc_force_value_out(ccv), .service_irq_out(srv),
    .reset_vector_out(rvec), .irq_any_in(iany), .irq_ext_in(iext), .irq_halt_in(ihalt),
    .irq_time_base_in(itb), .wake_reset_in(wrst), .wdg_enabled_in(wdg_en),
    .wdg_reset_out(wdgr), .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en),
    .time_base_clk_en_out(tb_en), .osc_enable_out(osc_en), .mode_out(mode));

  psmc_cpu_model cpu (
    .clk_sys_in(clk_sys_in), .service_irq_in(srv), .reset_vector_in(rvec),
    .instr_valid_out(iv), .opcode_out(op), .wfi_out(wait_for_interrupt_instr), .irq_any_out(iany),
    .irq_ext_out(iext), .irq_halt_out(ihalt), .irq_time_base_out(itb),
    .wake_reset_out(wrst));

  initial clk_sys_in = 1'b0;
  always #50 clk_sys_in = ~clk_sys_in;

  always @(posedge clk_sys_in) begin
    cyc   <= cyc + 1;
    wdg_n <= wdg_n + int'(wdgr === 1'b1);
    cpu_n <= cpu_n + int'(cpu_en === 1'b1);
    per_n <= per_n + int'(per_en === 1'b1);
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // no wait-state count is assumed; the loop bound only catches a dead slave
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_in);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk_sys_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    chk(n < 50, 1'b1);
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdv, exp);
    chk(err, e);
  endtask : rdchk
  // waits for the wake pulse; dt counts edges from the call, vec tells reset from irq
  task automatic wake_wait(input int lim);
    dt = 0;
    do begin
      @(posedge clk_sys_in);
      dt++;
    end while (srv !== 1'b1 && rvec !== 1'b1 && dt < lim);
    vec = rvec;
    #1;
  endtask : wake_wait
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_in, clk_en, psel, penable, pwrite, wdg_en, paddr, pwdata} = {2'b11, 4'h0, 44'h0};
    {fail_count, n_compared, cyc, wdg_n, cpu_n, per_n} = '0;
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1;
    chk({mode, cpu_en, per_en, tb_en, osc_en}, 7'h0F);
    rdchk(psmc_pkg::ADDR_CTRL, 32'h0000_0000, 1'b0);
    apb(1'b1, psmc_pkg::ADDR_CTRL, 32'hFFFF_FFC0);
    rdchk(psmc_pkg::ADDR_CTRL, 32'h0000_0000, 1'b0);
    apb(1'b1, psmc_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    rdchk(psmc_pkg::ADDR_STATUS, 32'h0000_0000, 1'b0);
    rdchk(12'h008, 32'h0000_0000, 1'b1);
    $display("test registers done");
    // slow divider sweep: cpu ticks over 64 cycles follow the divide ratio
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, psmc_pkg::ADDR_CTRL, 32'(1 + 2 * k));
      repeat (4) @(posedge clk_sys_in);
      #1 c0 = cpu_n;
      repeat (64) @(posedge clk_sys_in);
      #1 chk(cpu_n - c0, 64 >> (k + 1));
      chk(mode, psmc_pkg::ST_SLOW);
    end
    cpu.exec(8'h00, 1'b1);
    #1 chk({mode, ccf, ccv}, {psmc_pkg::ST_SLOW_WAIT, 3'b110});
    c0 = cpu_n;
    p0 = per_n;
    repeat (32) @(posedge clk_sys_in);
    #1 chk({16'(cpu_n - c0), 16'(per_n - p0)}, 32'h0000_0002);
    cpu.raise(5'h01);
    wake_wait(20);
    chk({vec, dt <= 3, mode}, {2'b01, psmc_pkg::ST_SLOW});
    $display("test slow and slow-wait done");
    apb(1'b1, psmc_pkg::ADDR_CTRL, 32'h0000_0000);
    cpu.exec(8'h00, 1'b1);
    #1 chk({mode, ccf}, {psmc_pkg::ST_WAIT, 1'b1});
    c0 = cpu_n;
    p0 = per_n;
    repeat (16) @(posedge clk_sys_in);
    #1 chk({16'(cpu_n - c0), 16'(per_n - p0)}, 32'h0000_0010);
    cpu.raise(5'h10);
    wake_wait(20);
    chk({vec, mode}, {1'b1, psmc_pkg::ST_RUN});
    $display("test wait done");
    // full halt with watchdog-halt option: short then long stabilisation
    @(posedge clk_sys_in) wdg_en <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, psmc_pkg::ADDR_CTRL, 32'h20 | 32'(k << 4));
      w0 = wdg_n;
      cpu.exec(psmc_pkg::HALT_OPCODE, 1'b0);
      #1 chk({mode, ccf, cpu_en, per_en, tb_en, osc_en}, {psmc_pkg::ST_HALT, 5'h10});
      repeat (3) @(posedge clk_sys_in);
      cpu.raise(5'h04);
      wake_wait(40);
      chk(dt - (k ? LONG_N : SHORT_N) <= 3, 1'b1);
      chk({vec, 16'(wdg_n - w0)}, 32'h0000_0001);
    end
    cpu.exec(8'h8F, 1'b0);
    #1 chk(mode, psmc_pkg::ST_RUN);
    $display("test halt done");
    // active-halt: time base, external and reset wake, watchdog never fires
    apb(1'b1, psmc_pkg::ADDR_CTRL, 32'h0000_0028);
    for (int k = 0; k < 3; k++) begin
      w0 = wdg_n;
      cpu.exec(psmc_pkg::HALT_OPCODE, 1'b0);
      #1 chk({mode, ccf, cpu_en, per_en, tb_en, osc_en}, {psmc_pkg::ST_ACT_HALT, 5'h13});
      repeat (3) @(posedge clk_sys_in);
      cpu.raise(src[k]);
      wake_wait(40);
      chk({vec, dt <= 3}, {k == 2, k != 2});
      chk(wdg_n - w0, 0);
      repeat (20) @(posedge clk_sys_in);
    end
    // clearing the oscillator irq enable inside the post-wake guard parks the cpu
    cpu.exec(psmc_pkg::HALT_OPCODE, 1'b0);
    cpu.raise(5'h08);
    wake_wait(40);
    apb(1'b1, psmc_pkg::ADDR_CTRL, 32'h0000_0000);
    #1 chk(mode, psmc_pkg::ST_RUN);
    @(posedge clk_sys_in);
    #1 chk({mode, cpu_en}, {psmc_pkg::ST_STAB, 1'b0});
    repeat (3) @(posedge clk_sys_in);
    rdchk(psmc_pkg::ADDR_STATUS, 32'h0000_0030, 1'b0);
    $display("test active-halt done");
    // an interrupt already pending at halt entry must wake after only the short stabilisation delay
    cpu.raise(5'h04);
    cpu.exec(psmc_pkg::HALT_OPCODE, 1'b0);
    wake_wait(40);
    chk({vec, dt <= SHORT_N + 3}, 2'b01);
    $display("test pending wake done");
    close_out();
  end
endmodule : psmc_ctrl_tb

// ==== psmc_pkg.sv ====
// shared constants, state encodings and register layout of the power mode controller
package psmc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // apb register map (byte addresses) and field layout
  localparam logic [11:0] ADDR_CTRL        = 12'h000;
  localparam logic [11:0] ADDR_STATUS      = 12'h004;
  localparam int          CTRL_WIDTH       = 6;
  localparam int          CTRL_SLOW_BIT    = 0;
  localparam int          CTRL_DIV_LSB     = 1;
  localparam int          CTRL_OIE_BIT     = 3;
  localparam int          CTRL_LONGDLY_BIT = 4;
  localparam int          CTRL_WDGH_BIT    = 5;
  localparam logic [5:0]  CTRL_RESET       = 6'h00;
  localparam int          STAT_MODE_LSB    = 0;
  localparam int          STAT_GUARD_BIT   = 3;
  localparam int          STAT_WAKE_LSB    = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // instruction decode and forced priority level
  localparam logic [7:0]  HALT_OPCODE      = 8'h8E;
  localparam logic [1:0]  CC_FORCE_VAL     = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // wake-up stabilisation delay, in master clock cycles
  localparam int          STAB_SHORT_CYC   = 256;
  localparam int          STAB_LONG_CYC    = 4096;
  localparam int          DLY_WIDTH        = 13;

  ////////////////////////////////////////////////////////////////////////////////
  // power modes, gray coded along run-slow-slowwait-wait and halt-stab
  typedef enum logic [2:0] {
    ST_RUN       = 3'h0,
    ST_SLOW      = 3'h1,
    ST_SLOW_WAIT = 3'h3,
    ST_WAIT      = 3'h2,
    ST_ACT_HALT  = 3'h6,
    ST_HALT      = 3'h7,
    ST_STAB      = 3'h5
  } psmc_state_t;

  typedef enum logic [1:0] {
    WK_IRQ    = 2'h0,
    WK_RESET  = 2'h1,
    WK_RESUME = 2'h3
  } psmc_wake_t;

  typedef struct packed {
    psmc_state_t          state;
    logic [5:0]           ctrl;
    logic [3:0]           div_cnt;
    logic [DLY_WIDTH-1:0] dly_cnt;
    logic                 guard;
    psmc_wake_t           wake;
    logic                 cc_force;
    logic                 service;
    logic                 rst_vec;
    logic                 wdg_rst;
    logic                 cpu_en;
    logic                 per_en;
    logic                 tb_en;
    logic                 osc_en;
    logic [31:0]          prdata;
    logic                 pslverr;
  } psmc_regs_t;

  localparam psmc_regs_t REGS_RESET = '{
    state: ST_RUN, ctrl: CTRL_RESET, div_cnt: 4'h0, dly_cnt: 13'h0000,
    guard: 1'b0, wake: WK_IRQ, cc_force: 1'b0, service: 1'b0, rst_vec: 1'b0,
    wdg_rst: 1'b0, cpu_en: 1'b1, per_en: 1'b1, tb_en: 1'b1, osc_en: 1'b1,
    prdata: 32'h0000_0000, pslverr: 1'b0};

endpackage : psmc_pkg
